// *** hdl/scm_pkg.sv ***
// Overview of operation
// - After any reset the system runs from the halved slow RC oscillator.
// - The slow RC oscillator always runs; software cannot stop it.
// - The crystal oscillator is off when reset ends.
// - Fast RC trim is 8 bits: 0x00 fastest, 0xff slowest, monotonic.
// - Slow RC trim is 5 bits in 4:0, 0x00 fastest; bits 7:5 reserved.
// - Crystal bias trim is 2 bits: 0x00 most bias, 0x03 least.
// - Fast RC trim survives sleep; only power-on reset changes it.
// - PLL output is the 11-bit multiplier in bits 10:0 times the crystal.
// - The PLL reference is the undivided crystal clock.
// - Core divider bits 7:5 divide by 1,2,3,4,6,8,12,24.
// - The core divider applies only with fast RC or PLL selected.
// - PLL, crystal and main RC run only while bits 4, 3, 2 are set.
// - Source select 00 slow aux, 01 main RC, 10 PLL divided by 4.
// - Select value 11 flags a clock fault and the aux clock runs.
// - A software-enabled clock monitor interrupt reports failure of the oscillator feeding the active source.
// - When configured, wake-up switches the system clock to the main RC.
// - ADC sampling divider bit: 0 divides by 24, 1 by 12.
// - Charge pump field: 250 kHz, 500 kHz, 1 MHz, 2 MHz; reset 10.
// - LCD pump field: 16.384 kHz crystal half, 250k, 500k, 1 MHz; reset 00.
package scm_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [31:0] OFF_SYS_CLOCK_CONTROL  = 32'h50000000;
  localparam logic [31:0] OFF_FUNC_CLOCK_CONTROL = 32'h50000003;
  localparam logic [31:0] OFF_PLL_FEEDBACK_DIV   = 32'h500180d6;
  localparam logic [31:0] OFF_CRYSTAL_BIAS_TRIM  = 32'h500180e0;
  localparam logic [31:0] OFF_SLOW_RC_TRIM       = 32'h500180e4;
  localparam logic [31:0] OFF_FAST_RC_TRIM       = 32'h500180e5;
  localparam logic [31:0] OFF_MONITOR_CONTROL    = 32'h500180f0;
  localparam logic [31:0] OFF_CLOCK_STATUS       = 32'h500180f1;
  // Index of a register on the bus is the low part of its offset
  localparam int          IDX_W                  = 12;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  RST_SYS_CLOCK_CONTROL  = 8'h45;
  localparam logic [4:0]  RST_FUNC_CLOCK_CONTROL = 5'h08;
  localparam logic [10:0] RST_PLL_FEEDBACK_DIV   = 11'h5b9;
  localparam logic [1:0]  RST_CRYSTAL_BIAS_TRIM  = 2'h3;
  localparam logic [4:0]  RST_SLOW_RC_TRIM       = 5'h10;
  localparam logic [7:0]  RST_FAST_RC_TRIM       = 8'h80;
  localparam logic [1:0]  RST_MONITOR_CONTROL    = 2'h0;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int POS_CKD      = 5;
  localparam int POS_PLL_ON   = 4;
  localparam int POS_XO_ON    = 3;
  localparam int POS_RC_ON    = 2;
  localparam int POS_ADC_DIV  = 4;
  localparam int POS_ACP      = 2;
  localparam int POS_LCD      = 0;
  localparam int POS_MON_IE   = 0;
  localparam int POS_WAKE_RC  = 1;
  localparam int POS_FAULT    = 2;
  localparam int RDY_RC       = 0;
  localparam int RDY_XO       = 1;
  localparam int RDY_PLL      = 2;

  // ************************************************************
  // Source select codes and ratios
  // ************************************************************
  localparam logic [1:0] SRC_AUX    = 2'h0;
  localparam logic [1:0] SRC_RC     = 2'h1;
  localparam logic [1:0] SRC_PLL    = 2'h2;
  localparam logic [1:0] SRC_FAULT  = 2'h3;
  localparam logic [4:0] ADC_DIV_SLOW = 5'h18;
  localparam logic [4:0] ADC_DIV_FAST = 5'h0c;
  localparam logic [4:0] DIV_ONE      = 5'h01;

  // Core divider code to ratio
  function automatic logic [4:0] scm_ckd_ratio(input logic [2:0] code);
    case (code)
      3'h0:    scm_ckd_ratio = 5'h01;
      3'h1:    scm_ckd_ratio = 5'h02;
      3'h2:    scm_ckd_ratio = 5'h03;
      3'h3:    scm_ckd_ratio = 5'h04;
      3'h4:    scm_ckd_ratio = 5'h06;
      3'h5:    scm_ckd_ratio = 5'h08;
      3'h6:    scm_ckd_ratio = 5'h0c;
      default: scm_ckd_ratio = 5'h18;
    endcase
  endfunction : scm_ckd_ratio

endpackage : scm_pkg

// *** hdl/scm_system_clock_manager.sv ***
// Our own choice: the APB register port.
module scm_system_clock_manager (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        main_rc_ready,
  input  wire logic        crystal_ready,
  input  wire logic        pll_locked,
  input  wire logic        wake_event,
  output logic             slow_rc_on,
  output logic             main_rc_on,
  output logic             crystal_osc_on,
  output logic             pll_on,
  output logic      [10:0] feedback_multiplier,
  output logic      [7:0]  fast_rc_trim_code,
  output logic      [4:0]  slow_rc_trim_code,
  output logic      [1:0]  crystal_bias_code,
  output logic      [1:0]  active_source,
  output logic      [4:0]  core_divide_ratio,
  output logic      [4:0]  adc_divide_ratio,
  output logic      [1:0]  charge_pump_select,
  output logic      [1:0]  lcd_pump_select,
  output logic             clock_monitor_irq
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0]  sysctl;
    logic [4:0]  fnctl;
    logic [10:0] fbdiv;
    logic [1:0]  xbias;
    logic [4:0]  lftrim;
    logic [7:0]  hftrim;
    logic [1:0]  moncfg;
    logic        fault;
    logic [1:0]  active;
    logic [2:0]  s1;
    logic [2:0]  s2;
    logic [2:0]  s3;
    logic [2:0]  rdy;
    logic [31:0] rdata;
    logic        err;
  } scm_state_t;

  scm_state_t q;
  scm_state_t d;

  localparam int IDX_W = scm_pkg::IDX_W;
  localparam logic [IDX_W-1:0] I_SYS  = scm_pkg::OFF_SYS_CLOCK_CONTROL[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_FUNC = scm_pkg::OFF_FUNC_CLOCK_CONTROL[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_PLL  = scm_pkg::OFF_PLL_FEEDBACK_DIV[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_XB   = scm_pkg::OFF_CRYSTAL_BIAS_TRIM[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_LF   = scm_pkg::OFF_SLOW_RC_TRIM[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_HF   = scm_pkg::OFF_FAST_RC_TRIM[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_MON  = scm_pkg::OFF_MONITOR_CONTROL[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_STAT = scm_pkg::OFF_CLOCK_STATUS[IDX_W-1:0];

  // A source counts as running once its filtered ready is seen
  function automatic logic src_ready(input logic [1:0] src, input logic [2:0] rdy);
    case (src)
      scm_pkg::SRC_RC:  src_ready = rdy[scm_pkg::RDY_RC];
      scm_pkg::SRC_PLL: src_ready = rdy[scm_pkg::RDY_PLL] & rdy[scm_pkg::RDY_XO];
      default:          src_ready = 1'b1;
    endcase
  endfunction : src_ready

  logic [IDX_W-1:0] idx;
  logic             hit;
  logic             setup_ph;
  logic             wr_acc;

  // ************************************************************
  // Bus decode
  // ************************************************************
  assign idx      = paddr[13:2];
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & ~q.err;

  // Unmapped index or a byte offset inside a word is refused
  always_comb begin
    case (idx)
      I_SYS, I_FUNC, I_PLL, I_XB, I_LF, I_HF, I_MON, I_STAT: hit = (paddr[1:0] == 2'h0);
      default: hit = 1'b0;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    d = q;
    // Three stage sync; a level is taken once the last two agree
    d.s1 = {pll_locked, crystal_ready, main_rc_ready};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 3; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.rdy[i] = q.s3[i];
      end
    end

    // Read data is captured in the setup phase so prdata is a flop
    if (setup_ph) begin
      d.err   = ~hit;
      d.rdata = 32'h0;
      case (idx)
        I_SYS:   d.rdata[7:0]  = q.sysctl;
        I_FUNC:  d.rdata[4:0]  = q.fnctl;
        I_PLL:   d.rdata[10:0] = q.fbdiv;
        I_XB:    d.rdata[1:0]  = q.xbias;
        I_LF:    d.rdata[4:0]  = q.lftrim;
        I_HF:    d.rdata[7:0]  = q.hftrim;
        I_MON:   d.rdata[2:0]  = {q.fault, q.moncfg};
        I_STAT:  d.rdata[4:0]  = {q.rdy, q.active};
        default: d.rdata       = 32'h0;
      endcase
    end

    // Register writes; reserved bits are dropped
    if (wr_acc) begin
      case (idx)
        I_SYS:  d.sysctl = pwdata[7:0];
        I_FUNC: d.fnctl  = pwdata[4:0];
        I_PLL:  d.fbdiv  = pwdata[10:0];
        I_XB:   d.xbias  = pwdata[1:0];
        I_LF:   d.lftrim = pwdata[4:0];
        I_HF:   d.hftrim = pwdata[7:0];
        I_MON: begin
          d.moncfg = pwdata[1:0];
          if (pwdata[scm_pkg::POS_FAULT]) begin
            d.fault = 1'b0;
          end
        end
        default: d.err = q.err;
      endcase
    end

    // Wake-up turns the main RC on and requests it
    if (wake_event && q.moncfg[scm_pkg::POS_WAKE_RC]) begin
      d.sysctl[scm_pkg::POS_RC_ON] = 1'b1;
      d.sysctl[1:0]                = scm_pkg::SRC_RC;
    end

    // The active source moves only to a source already running,
    // so the external mux never sees a dead or starting clock
    if (q.sysctl[1:0] == scm_pkg::SRC_FAULT) begin
      d.active = scm_pkg::SRC_AUX;
    end else if (q.sysctl[1:0] != q.active && src_ready(q.sysctl[1:0], q.rdy)) begin
      d.active = q.sysctl[1:0];
    end

    // Monitor last so a failure wins over a same-cycle write or clear
    if (q.active != scm_pkg::SRC_AUX && !src_ready(q.active, q.rdy)) begin
      d.active       = scm_pkg::SRC_AUX;
      d.sysctl[1:0]  = scm_pkg::SRC_FAULT;
      d.fault        = 1'b1;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Power-on reset only: sleep never touches the trims
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.sysctl <= scm_pkg::RST_SYS_CLOCK_CONTROL;
      q.fnctl  <= scm_pkg::RST_FUNC_CLOCK_CONTROL;
      q.fbdiv  <= scm_pkg::RST_PLL_FEEDBACK_DIV;
      q.xbias  <= scm_pkg::RST_CRYSTAL_BIAS_TRIM;
      q.lftrim <= scm_pkg::RST_SLOW_RC_TRIM;
      q.hftrim <= scm_pkg::RST_FAST_RC_TRIM;
      q.moncfg <= scm_pkg::RST_MONITOR_CONTROL;
      q.fault  <= 1'b0;
      q.active <= scm_pkg::SRC_AUX;
      q.s1     <= 3'h0;
      q.s2     <= 3'h0;
      q.s3     <= 3'h0;
      q.rdy    <= 3'h0;
      q.rdata  <= 32'h0;
      q.err    <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Zero wait state slave; error only on a refused access
  assign pready  = 1'b1;
  assign pslverr = psel & penable & q.err;
  assign prdata  = q.rdata;

  // Main RC, crystal and PLL enables straight from control bits; slow RC tied on
  assign slow_rc_on     = 1'b1;
  assign main_rc_on     = q.sysctl[scm_pkg::POS_RC_ON];
  assign crystal_osc_on = q.sysctl[scm_pkg::POS_XO_ON];
  assign pll_on         = q.sysctl[scm_pkg::POS_PLL_ON];

  // The PLL multiplies the undivided crystal by this value
  assign feedback_multiplier = q.fbdiv;
  assign fast_rc_trim_code   = q.hftrim;
  assign slow_rc_trim_code   = q.lftrim;
  assign crystal_bias_code   = q.xbias;
  assign active_source       = q.active;

  // The divider is bypassed on the slow aux clock
  assign core_divide_ratio = (q.active == scm_pkg::SRC_RC || q.active == scm_pkg::SRC_PLL)
                           ? scm_pkg::scm_ckd_ratio(q.sysctl[7:scm_pkg::POS_CKD])
                           : scm_pkg::DIV_ONE;

  // Function clock selections
  assign adc_divide_ratio   = q.fnctl[scm_pkg::POS_ADC_DIV] ? scm_pkg::ADC_DIV_FAST
                                                            : scm_pkg::ADC_DIV_SLOW;
  assign charge_pump_select = q.fnctl[scm_pkg::POS_ACP+1:scm_pkg::POS_ACP];
  assign lcd_pump_select    = q.fnctl[scm_pkg::POS_LCD+1:scm_pkg::POS_LCD];
  assign clock_monitor_irq  = q.fault & q.moncfg[scm_pkg::POS_MON_IE];

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fault_to_aux: assert property (
    (q.active != scm_pkg::SRC_AUX && !src_ready(q.active, q.rdy))
    |=> (active_source == scm_pkg::SRC_AUX && q.sysctl[1:0] == scm_pkg::SRC_FAULT && q.fault))
    else $error("failed source did not fall back to aux");

  a_switch_when_ready: assert property (
    ($changed(active_source) && active_source != scm_pkg::SRC_AUX)
    |-> src_ready(active_source, $past(q.rdy)))
    else $error("switched to a source that was not running");

  a_fault_sel_aux: assert property (
    (q.sysctl[1:0] == scm_pkg::SRC_FAULT) |=> (active_source == scm_pkg::SRC_AUX))
    else $error("fault code shown but aux not active");

  a_div_bypass: assert property (
    (active_source == scm_pkg::SRC_AUX) |-> (core_divide_ratio == 5'h01))
    else $error("core divider applied on aux clock");

  a_div_top_code: assert property (
    (active_source == scm_pkg::SRC_PLL && q.sysctl[7:5] == 3'h7) |-> (core_divide_ratio == 5'h18))
    else $error("divider code 111 not divide by 24");

  a_sync_agree: assert property (
    $changed(q.rdy) |-> (((q.rdy ^ $past(q.rdy))
      & (($past(q.s2) ^ $past(q.s3)) | (q.rdy ^ $past(q.s3)))) == 3'h0))
    else $error("ready taken before sync stages agreed");

  // The fault code is a select value only, never a mux setting
  a_active_legal: assert property (
    active_source != scm_pkg::SRC_FAULT)
    else $error("active source shows the fault code");

  // PLL stays selected only while its crystal reference was running
  a_pll_ref_crystal: assert property (
    (active_source == scm_pkg::SRC_PLL) |-> $past(q.rdy[scm_pkg::RDY_XO]))
    else $error("PLL active without a running crystal reference");

  a_wake_rc: assert property (
    (wake_event && q.moncfg[1] && !(q.active != scm_pkg::SRC_AUX && !src_ready(q.active, q.rdy)))
    |=> (q.sysctl[1:0] == scm_pkg::SRC_RC && main_rc_on))
    else $error("wake did not request the main RC");

  a_irq_on_fault: assert property (
    ($rose(q.fault) && q.moncfg[0]) |-> clock_monitor_irq ##1 (clock_monitor_irq || !q.moncfg[0]
      || !q.fault))
    else $error("monitor interrupt missing on fault");

  a_slow_rc_run: assert property (
    slow_rc_on [*3])
    else $error("slow RC stopped");

  a_apb_refuse: assert property (
    (setup_ph && !hit) |=> (penable -> pslverr))
    else $error("unmapped access not refused");

  c_switch_rc: cover property ($changed(active_source) ##0 active_source == scm_pkg::SRC_RC);
  c_switch_pll: cover property ($changed(active_source) ##0 active_source == scm_pkg::SRC_PLL);
  c_fault: cover property ($rose(q.fault));
  c_wake: cover property (wake_event && q.moncfg[1]);

endmodule : scm_system_clock_manager

// *** test/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Signals and register addresses
  // ****************************************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        main_rc_ready, crystal_ready, pll_locked, wake_event, e;
  logic        slow_rc_on, main_rc_on, crystal_osc_on, pll_on, clock_monitor_irq;
  logic [10:0] feedback_multiplier;
  logic [7:0]  fast_rc_trim_code;
  logic [4:0]  slow_rc_trim_code, core_divide_ratio, adc_divide_ratio;
  logic [1:0]  crystal_bias_code, active_source, charge_pump_select, lcd_pump_select;
  int          n_mismatch, checks_done;
  // Byte address is four times the index, the index being the low offset bits
  localparam logic [13:0] A_SYS  = {scm_pkg::OFF_SYS_CLOCK_CONTROL[11:0], 2'b00};
  localparam logic [13:0] A_FUNC = {scm_pkg::OFF_FUNC_CLOCK_CONTROL[11:0], 2'b00};
  localparam logic [13:0] A_PLL  = {scm_pkg::OFF_PLL_FEEDBACK_DIV[11:0], 2'b00};
  localparam logic [13:0] A_XB   = {scm_pkg::OFF_CRYSTAL_BIAS_TRIM[11:0], 2'b00};
  localparam logic [13:0] A_SLOW = {scm_pkg::OFF_SLOW_RC_TRIM[11:0], 2'b00};
  localparam logic [13:0] A_FAST = {scm_pkg::OFF_FAST_RC_TRIM[11:0], 2'b00};
  localparam logic [13:0] A_MON  = {scm_pkg::OFF_MONITOR_CONTROL[11:0], 2'b00};
  localparam logic [13:0] A_STAT = {scm_pkg::OFF_CLOCK_STATUS[11:0], 2'b00};
  localparam logic [4:0]  RATIO [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h18};

  scm_system_clock_manager scm_system_clock_manager_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .main_rc_ready, .crystal_ready, .pll_locked, .wake_event, .slow_rc_on, .main_rc_on,
    .crystal_osc_on, .pll_on, .feedback_multiplier, .fast_rc_trim_code, .slow_rc_trim_code,
    .crystal_bias_code, .active_source, .core_divide_ratio, .adc_divide_ratio,
    .charge_pump_select, .lcd_pump_select, .clock_monitor_irq
  );

  // Free running bus clock, 40 ns period
  always #20 pclk = ~pclk;

  // ****************************************************************
  // Bus tasks and comparisons
  // ****************************************************************
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_mismatch++;
      $display("unexpected pready: expected 1 seen timeout");
      test_done();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input string what, input logic [13:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask : rd

  // Bounded wait for the source that the outside mux must run
  task automatic wait_src(input logic [1:0] s);
    for (int i = 0; i < 40; i++) begin
      @(negedge pclk);
      if (active_source === s) break;
    end
    chk("active source", 32'(s), 32'(active_source));
    if (active_source !== s) begin
      test_done();
    end
  endtask : wait_src

  // One-cycle wake request from the power manager
  task automatic wake_pulse();
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
  endtask : wake_pulse

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    main_rc_ready = 0; crystal_ready = 0; pll_locked = 0; wake_event = 0;
    n_mismatch = 0; checks_done = 0;
    @(negedge pclk);
    chk("source in reset", 32'h0, 32'(active_source));
    @(posedge pclk);
    presetn <= 1'b1;
    // Main RC not yet running, so the aux clock must stay in charge
    repeat (8) @(negedge pclk);
    chk("source before rc ready", 32'h0, 32'(active_source));
    chk("crystal on", 32'h0, 32'(crystal_osc_on));
    chk("slow rc on", 32'h1, 32'(slow_rc_on));
    chk("adc ratio", 32'h18, 32'(adc_divide_ratio));
    rd("sys reset", A_SYS, 32'h45);
    rd("func reset", A_FUNC, 32'h08);
    rd("pll reset", A_PLL, 32'h5b9);
    rd("xbias reset", A_XB, 32'h03);
    rd("slow reset", A_SLOW, 32'h10);
    rd("fast reset", A_FAST, 32'h80);
    main_rc_ready <= 1'b1;
    wait_src(2'h1);
    $display("test reset finished");

    // Trims keep only their documented widths; reserved bits read zero
    apb(1'b1, A_FAST, 32'hffff_ff5a);
    rd("fast trim", A_FAST, 32'h5a);
    chk("fast trim code", 32'h5a, 32'(fast_rc_trim_code));
    apb(1'b1, A_SLOW, 32'hff);
    rd("slow trim", A_SLOW, 32'h1f);
    chk("slow trim code", 32'h1f, 32'(slow_rc_trim_code));
    apb(1'b1, A_XB, 32'hfe);
    rd("xbias", A_XB, 32'h02);
    chk("xbias code", 32'h2, 32'(crystal_bias_code));
    apb(1'b1, A_PLL, 32'hfe00);
    rd("pll div", A_PLL, 32'h600);
    $display("test trims finished");

    // Every divider code with the main RC selected, then ignored on aux
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, A_SYS, 32'({c[2:0], 5'b00101}));
      @(negedge pclk);
      chk("core ratio", 32'(RATIO[c]), 32'(core_divide_ratio));
    end
    apb(1'b1, A_SYS, 32'he4);
    wait_src(2'h0);
    chk("core ratio on aux", 32'h1, 32'(core_divide_ratio));
    apb(1'b1, A_SYS, 32'h05);
    wait_src(2'h1);
    $display("test divider finished");

    // Every function clock setting, reserved bits dropped
    for (int v = 0; v < 32; v++) begin
      apb(1'b1, A_FUNC, 32'(v) | 32'he0);
      rd("func", A_FUNC, 32'(v));
      chk("adc ratio", v[4] ? 32'h0c : 32'h18, 32'(adc_divide_ratio));
      chk("pump select", 32'(v[3:2]), 32'(charge_pump_select));
      chk("lcd select", 32'(v[1:0]), 32'(lcd_pump_select));
    end
    $display("test function clocks finished");

    // Crystal and multiplier first, then PLL; switch waits for both to run
    apb(1'b1, A_PLL, 32'd1465);
    apb(1'b1, A_SYS, 32'h0d);
    apb(1'b1, A_SYS, 32'h3e);
    pll_locked <= 1'b1;
    repeat (8) @(negedge pclk);
    chk("pll on", 32'h1, 32'(pll_on));
    chk("crystal on", 32'h1, 32'(crystal_osc_on));
    chk("multiplier", 32'd1465, 32'(feedback_multiplier));
    chk("source without crystal", 32'h1, 32'(active_source));
    crystal_ready <= 1'b1;
    wait_src(2'h2);
    chk("core ratio pll", 32'h2, 32'(core_divide_ratio));
    rd("status pll", A_STAT, 32'h1e);
    $display("test pll finished");

    // Losing the running source flags a fault and falls back to aux
    apb(1'b1, A_MON, 32'h1);
    crystal_ready <= 1'b0;
    wait_src(2'h0);
    @(negedge pclk);
    chk("monitor irq", 32'h1, 32'(clock_monitor_irq));
    chk("core ratio fault", 32'h1, 32'(core_divide_ratio));
    rd("sys fault", A_SYS, 32'h3f);
    rd("mon fault", A_MON, 32'h5);
    apb(1'b1, A_MON, 32'h5);
    rd("mon cleared", A_MON, 32'h1);
    chk("irq cleared", 32'h0, 32'(clock_monitor_irq));
    $display("test fault finished");

    // Wake pulse moves the system to the main RC
    apb(1'b1, A_SYS, 32'h00);
    wait_src(2'h0);
    chk("main rc on", 32'h0, 32'(main_rc_on));
    chk("slow rc on", 32'h1, 32'(slow_rc_on));
    wake_pulse();
    rd("sys wake disabled", A_SYS, 32'h00);
    main_rc_ready <= 1'b0;
    apb(1'b1, A_MON, 32'h2);
    wake_pulse();
    @(negedge pclk);
    chk("main rc after wake", 32'h1, 32'(main_rc_on));
    rd("sys after wake", A_SYS, 32'h05);
    main_rc_ready <= 1'b1;
    wait_src(2'h1);
    $display("test wake finished");

    // Unmapped and misaligned accesses are refused and change nothing
    apb(1'b0, 14'h004, 32'h0);
    chk("unmapped error", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, q);
    apb(1'b1, 14'h002, 32'hff);
    chk("misaligned error", 32'h1, 32'(e));
    rd("sys unchanged", A_SYS, 32'h05);
    $display("test refused finished");

    // Second reset in mid-run restarts on aux
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk("source in reset", 32'h0, 32'(active_source));
    chk("crystal in reset", 32'h0, 32'(crystal_osc_on));
    @(posedge pclk);
    presetn <= 1'b1;
    rd("sys after reset", A_SYS, 32'h45);
    wait_src(2'h1);
    $display("test second reset finished");
    test_done();
  end
endmodule : tb_top
